// ==== bst_pkg.sv ====
package bst_pkg;

  // ----------------------------------------------------------------
  // Instruction register defaults
  // ----------------------------------------------------------------
  localparam int IR_LEN_DEF = 4;
  localparam logic [3:0] OP_EXTEST_DEF = 4'h0;
  localparam logic [3:0] OP_SAMPLE_DEF = 4'h1;
  localparam logic [3:0] OP_IDCODE_DEF = 4'h2;
  localparam logic [3:0] OP_USERCODE_DEF = 4'h3;
  localparam logic [3:0] OP_CLAMP_DEF = 4'h4;
  localparam logic [3:0] OP_HIGHZ_DEF = 4'h5;

  // ----------------------------------------------------------------
  // Data registers
  // ----------------------------------------------------------------
  localparam int ID_LEN = 32;
  // Arbitrary identification value
  localparam logic [31:0] ID_VALUE_DEF = 32'h0a5a_c001;
  localparam logic [31:0] USER_SIG_DEF = 32'h0000_0000;
  localparam logic BYPASS_CAPTURE = 1'b0;
  localparam int NPINS_DEF = 8;

  // ----------------------------------------------------------------
  // Controller states and data register selection
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_RESET = 4'h0,
    ST_IDLE = 4'h1,
    ST_SEL_DR = 4'h2,
    ST_CAP_DR = 4'h3,
    ST_SH_DR = 4'h4,
    ST_EX1_DR = 4'h5,
    ST_PAU_DR = 4'h6,
    ST_EX2_DR = 4'h7,
    ST_UPD_DR = 4'h8,
    ST_SEL_IR = 4'h9,
    ST_CAP_IR = 4'ha,
    ST_SH_IR = 4'hb,
    ST_EX1_IR = 4'hc,
    ST_PAU_IR = 4'hd,
    ST_EX2_IR = 4'he,
    ST_UPD_IR = 4'hf
  } bst_tap_state_t;

  typedef enum logic [1:0] {
    SEL_BYP = 2'h0,
    SEL_BSR = 2'h1,
    SEL_ID = 2'h2,
    SEL_UC = 2'h3
  } bst_dr_sel_t;

endpackage : bst_pkg

// ==== bst_tap_fsm.sv ====
`timescale 1ns/10ps
module bst_tap_fsm import bst_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic tck_rise,
  input wire logic tms_s,
  input wire logic trst_n_s,
  output bst_tap_state_t state_ff
);

  bst_tap_state_t nxt_state;

  // ----------------------------------------------------------------
  // Standard sixteen-state graph
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_RESET: nxt_state = tms_s ? ST_RESET : ST_IDLE; // RULE12
      ST_IDLE: nxt_state = tms_s ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: nxt_state = tms_s ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: nxt_state = tms_s ? ST_EX1_DR : ST_SH_DR; // RULE21
      ST_SH_DR: nxt_state = tms_s ? ST_EX1_DR : ST_SH_DR; // RULE21
      ST_EX1_DR: nxt_state = tms_s ? ST_UPD_DR : ST_PAU_DR; // RULE22
      ST_PAU_DR: nxt_state = tms_s ? ST_EX2_DR : ST_PAU_DR;
      ST_EX2_DR: nxt_state = tms_s ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: nxt_state = tms_s ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: nxt_state = tms_s ? ST_RESET : ST_CAP_IR;
      ST_CAP_IR: nxt_state = tms_s ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR: nxt_state = tms_s ? ST_EX1_IR : ST_SH_IR; // RULE15
      ST_EX1_IR: nxt_state = tms_s ? ST_UPD_IR : ST_PAU_IR;
      ST_PAU_IR: nxt_state = tms_s ? ST_EX2_IR : ST_PAU_IR;
      ST_EX2_IR: nxt_state = tms_s ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: nxt_state = tms_s ? ST_SEL_DR : ST_IDLE;
    endcase
  end

  // Power-up reset and the test reset pin both force the reset state
  always_ff @(posedge clk) begin
    if (rst || !trst_n_s) begin
      state_ff <= ST_RESET; // RULE11 RULE12
    end else if (tck_rise) begin
      state_ff <= nxt_state; // RULE9
    end
  end

endmodule : bst_tap_fsm

// ==== bst_scan_cell.sv ====
`timescale 1ns/10ps
module bst_scan_cell #(
  parameter bit INPUT_ONLY = 1'b0,
  parameter bit SUPPLY_SEL = 1'b0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic cap,
  input wire logic shf,
  input wire logic upd,
  input wire logic ext_sel,
  input wire logic hiz,
  input wire logic keep_en,
  input wire logic scan_in,
  input wire logic pin_in,
  input wire logic core_out,
  input wire logic core_oe,
  output logic scan_out,
  output logic pin_out_ff,
  output logic pin_oe_ff,
  output logic pin_hold_ff,
  output logic core_in_ff
);

  // Stored enable bit is a tri-state request: 1 floats the pin
  logic out_cap_ff, hz_cap_ff, in_cap_ff;
  logic out_upd_ff, hz_upd_ff, in_upd_ff;
  logic mode_sel;
  logic nxt_drive;

  // Supply-select cells stay functional under EXTEST and CLAMP; HIGHZ still floats them
  assign mode_sel = ext_sel && !SUPPLY_SEL; // RULE1

  // ----------------------------------------------------------------
  // Capture and shift stages
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      out_cap_ff <= 1'b0;
      hz_cap_ff <= 1'b0;
      in_cap_ff <= 1'b0;
    end else if (cap) begin
      out_cap_ff <= INPUT_ONLY ? 1'b0 : core_out; // RULE1 RULE17
      hz_cap_ff <= INPUT_ONLY ? 1'b0 : !core_oe; // RULE1 RULE17
      in_cap_ff <= pin_in; // RULE17
    end else if (shf) begin
      out_cap_ff <= scan_in; // RULE19
      hz_cap_ff <= out_cap_ff;
      in_cap_ff <= hz_cap_ff;
    end
  end

  assign scan_out = in_cap_ff;

  always_ff @(posedge clk) begin
    if (rst) begin
      out_upd_ff <= 1'b0;
      hz_upd_ff <= 1'b1;
      in_upd_ff <= 1'b0;
    end else if (upd) begin
      out_upd_ff <= out_cap_ff; // RULE20
      hz_upd_ff <= hz_cap_ff;
      in_upd_ff <= in_cap_ff;
    end
  end

  // ----------------------------------------------------------------
  // Pin and core multiplexers
  // ----------------------------------------------------------------
  always_comb begin
    if (hiz) begin
      nxt_drive = 1'b0; // RULE5
    end else if (mode_sel) begin
      nxt_drive = !hz_upd_ff && !INPUT_ONLY; // RULE4 RULE25
    end else begin
      nxt_drive = core_oe && !INPUT_ONLY; // RULE18
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pin_out_ff <= 1'b0;
      pin_oe_ff <= 1'b0;
      pin_hold_ff <= 1'b0;
      core_in_ff <= 1'b0;
    end else begin
      pin_out_ff <= mode_sel ? out_upd_ff : core_out; // RULE4 RULE18
      pin_oe_ff <= nxt_drive;
      // Keeper wins over a test-requested float
      pin_hold_ff <= keep_en && (mode_sel || hiz) && !nxt_drive; // RULE8
      core_in_ff <= mode_sel ? in_upd_ff : pin_in; // RULE18
    end
  end

endmodule : bst_scan_cell

// ==== bst_tap_top.sv ====
`timescale 1ns/10ps
// Function
// (RULE1) Input-only cells capture zeros; supply cells functional
// (RULE2) Decode seven instructions, each selecting a path
// (RULE3) BYPASS puts one-bit stage in scan path
// (RULE4) CLAMP bypasses, pins driven from update stages
// (RULE5) HIGHZ bypasses and floats all pin drivers
// (RULE6) IDCODE shifts identification register out
// (RULE7) USERCODE shifts user signature register out
// (RULE8) Bus-hold or pull-up overrides test float
// (RULE9) Sixteen-state controller advances on rising TCK
// (RULE10) Reset state: normal operation, IR gets IDCODE
// (RULE11) Power-up starts in reset state
// (RULE12) Five TMS highs or TRST low resets
// (RULE13) Tester reaches IR shift with 0,1,1,0,0
// (RULE14) TDO driven only in shift states, falling edges
// (RULE15) IR shift state shifts IR out on TDO
// (RULE16) TDI sampled rising; last bit exits shift
// (RULE17) Capture loads pin, enable and output value
// (RULE18) SAMPLE keeps functional signals on pins
// (RULE19) Shift chains capture stages from TDI to TDO
// (RULE20) Update copies capture into retained update stages
// (RULE21) Capture then stay in shift while TMS low
// (RULE22) Two TMS highs from shift reach update
// (RULE23) All-ones instruction decodes as BYPASS
// (RULE24) Identification register is 32 bits
// (RULE25) Enable-stage one floats the pin driver
// (RULE26) IR length, opcodes, chain order are parameters; chain order is fixed here, entered at the highest cell index
module bst_tap_top import bst_pkg::*; #(
  parameter int NPINS = NPINS_DEF,
  parameter int IR_LEN = IR_LEN_DEF, // RULE26
  parameter logic [IR_LEN-1:0] OP_EXTEST = IR_LEN'(OP_EXTEST_DEF),
  parameter logic [IR_LEN-1:0] OP_SAMPLE = IR_LEN'(OP_SAMPLE_DEF),
  parameter logic [IR_LEN-1:0] OP_IDCODE = IR_LEN'(OP_IDCODE_DEF),
  parameter logic [IR_LEN-1:0] OP_USERCODE = IR_LEN'(OP_USERCODE_DEF),
  parameter logic [IR_LEN-1:0] OP_CLAMP = IR_LEN'(OP_CLAMP_DEF),
  parameter logic [IR_LEN-1:0] OP_HIGHZ = IR_LEN'(OP_HIGHZ_DEF),
  parameter bit HAS_IDCODE = 1'b1,
  parameter logic [31:0] ID_VALUE = ID_VALUE_DEF,
  parameter logic [31:0] USER_SIG = USER_SIG_DEF,
  parameter logic [NPINS-1:0] INPUT_ONLY = '0,
  parameter logic [NPINS-1:0] SUPPLY_SEL = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic trst_n,
  output logic tdo,
  output logic tdo_oe,
  output logic test_active,
  input wire logic [NPINS-1:0] pin_in,
  input wire logic [NPINS-1:0] keeper_en,
  input wire logic [NPINS-1:0] core_output_value,
  input wire logic [NPINS-1:0] core_output_enable,
  output logic [NPINS-1:0] pin_out,
  output logic [NPINS-1:0] pin_oe,
  output logic [NPINS-1:0] pin_hold,
  output logic [NPINS-1:0] core_input_drive
);

  localparam logic [IR_LEN-1:0] OP_BYPASS = '1;
  localparam logic [IR_LEN-1:0] IR_RESET = HAS_IDCODE ? OP_IDCODE : OP_BYPASS;

  // ----------------------------------------------------------------
  // Pin synchronisers and TCK edge detection
  // ----------------------------------------------------------------
  logic [3:0] sync_m_ff, sync_s_ff;
  logic [NPINS-1:0] pin_m_ff, pin_s_ff;
  logic tck_d_ff;
  logic tck_s, tms_s, tdi_s, trst_n_s;
  logic tck_rise, tck_fall;

  always_ff @(posedge clk) begin
    if (rst) begin
      sync_m_ff <= 4'h8;
      sync_s_ff <= 4'h8;
      tck_d_ff <= 1'b0;
      pin_m_ff <= '0;
      pin_s_ff <= '0;
    end else begin
      sync_m_ff <= {trst_n, tdi, tms, tck};
      sync_s_ff <= sync_m_ff;
      tck_d_ff <= sync_s_ff[0];
      pin_m_ff <= pin_in;
      pin_s_ff <= pin_m_ff;
    end
  end

  assign tck_s = sync_s_ff[0];
  assign tms_s = sync_s_ff[1];
  assign tdi_s = sync_s_ff[2];
  assign trst_n_s = sync_s_ff[3];
  assign tck_rise = tck_s && !tck_d_ff;
  assign tck_fall = !tck_s && tck_d_ff;

  // ----------------------------------------------------------------
  // Controller
  // ----------------------------------------------------------------
  bst_tap_state_t state;

  bst_tap_fsm u_fsm (
    .clk(clk),
    .rst(rst),
    .tck_rise(tck_rise),
    .tms_s(tms_s),
    .trst_n_s(trst_n_s),
    .state_ff(state)
  );

  // ----------------------------------------------------------------
  // Instruction register
  // ----------------------------------------------------------------
  logic [IR_LEN-1:0] ir_sh_ff, ir_ff;

  always_ff @(posedge clk) begin
    if (rst) begin
      ir_sh_ff <= IR_RESET;
    end else if (tck_rise && state == ST_CAP_IR) begin
      ir_sh_ff <= ir_ff; // RULE15
    end else if (tck_rise && state == ST_SH_IR) begin
      // Last bit taken on the edge that leaves the shift state
      ir_sh_ff <= {tdi_s, ir_sh_ff[IR_LEN-1:1]}; // RULE16
    end
  end

  // Update on the falling edge so the new mode settles mid-cycle
  always_ff @(posedge clk) begin
    if (rst || state == ST_RESET) begin
      ir_ff <= IR_RESET; // RULE10
    end else if (tck_fall && state == ST_UPD_IR) begin
      ir_ff <= ir_sh_ff;
    end
  end

  // ----------------------------------------------------------------
  // Instruction decode
  // ----------------------------------------------------------------
  bst_dr_sel_t dr_sel;
  logic ext_sel, hiz_sel;

  always_comb begin
    dr_sel = SEL_BYP; // RULE23
    ext_sel = 1'b0;
    hiz_sel = 1'b0;
    if (ir_ff == OP_EXTEST) begin
      dr_sel = SEL_BSR; // RULE2
      ext_sel = 1'b1;
    end else if (ir_ff == OP_SAMPLE) begin
      dr_sel = SEL_BSR; // RULE18
    end else if (ir_ff == OP_IDCODE && HAS_IDCODE) begin
      dr_sel = SEL_ID; // RULE6
    end else if (ir_ff == OP_USERCODE) begin
      dr_sel = SEL_UC; // RULE7
    end else if (ir_ff == OP_CLAMP) begin
      ext_sel = 1'b1; // RULE4
    end else if (ir_ff == OP_HIGHZ) begin
      hiz_sel = 1'b1; // RULE5
    end
  end

  // ----------------------------------------------------------------
  // Bypass and identification registers
  // ----------------------------------------------------------------
  logic byp_ff;
  logic [ID_LEN-1:0] id_sh_ff;
  logic cap_dr, sh_dr;

  assign cap_dr = tck_rise && state == ST_CAP_DR;
  assign sh_dr = tck_rise && state == ST_SH_DR;

  always_ff @(posedge clk) begin
    if (rst) begin
      byp_ff <= BYPASS_CAPTURE;
    end else if (cap_dr && dr_sel == SEL_BYP) begin
      byp_ff <= BYPASS_CAPTURE; // RULE3
    end else if (sh_dr && dr_sel == SEL_BYP) begin
      byp_ff <= tdi_s; // RULE3
    end
  end

  // One 32-bit shifter serves both signature instructions
  always_ff @(posedge clk) begin
    if (rst) begin
      id_sh_ff <= '0;
    end else if (cap_dr && dr_sel == SEL_ID) begin
      id_sh_ff <= ID_VALUE; // RULE24
    end else if (cap_dr && dr_sel == SEL_UC) begin
      id_sh_ff <= USER_SIG; // RULE7
    end else if (sh_dr && (dr_sel == SEL_ID || dr_sel == SEL_UC)) begin
      id_sh_ff <= {tdi_s, id_sh_ff[ID_LEN-1:1]}; // RULE6
    end
  end

  // ----------------------------------------------------------------
  // Boundary-scan chain, entered at the highest index
  // ----------------------------------------------------------------
  logic [NPINS:0] chain;
  logic bsr_cap, bsr_shf, bsr_upd;

  assign bsr_cap = cap_dr && dr_sel == SEL_BSR;
  assign bsr_shf = sh_dr && dr_sel == SEL_BSR;
  assign bsr_upd = tck_fall && state == ST_UPD_DR && dr_sel == SEL_BSR;
  assign chain[NPINS] = tdi_s;

  genvar gi;
  generate
    for (gi = 0; gi < NPINS; gi++) begin : g_cell
      bst_scan_cell #(
        .INPUT_ONLY(INPUT_ONLY[gi]),
        .SUPPLY_SEL(SUPPLY_SEL[gi])
      ) u_cell (
        .clk(clk),
        .rst(rst),
        .cap(bsr_cap),
        .shf(bsr_shf),
        .upd(bsr_upd),
        .ext_sel(ext_sel),
        .hiz(hiz_sel),
        .keep_en(keeper_en[gi]),
        .scan_in(chain[gi+1]),
        .pin_in(pin_s_ff[gi]),
        .core_out(core_output_value[gi]),
        .core_oe(core_output_enable[gi]),
        .scan_out(chain[gi]),
        .pin_out_ff(pin_out[gi]),
        .pin_oe_ff(pin_oe[gi]),
        .pin_hold_ff(pin_hold[gi]),
        .core_in_ff(core_input_drive[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // TDO driver, changes only on falling TCK
  // ----------------------------------------------------------------
  logic dr_so;

  always_comb begin
    unique case (dr_sel)
      SEL_BYP: dr_so = byp_ff;
      SEL_BSR: dr_so = chain[0];
      SEL_ID: dr_so = id_sh_ff[0];
      SEL_UC: dr_so = id_sh_ff[0];
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (tck_fall) begin
      tdo <= (state == ST_SH_IR) ? ir_sh_ff[0] : dr_so; // RULE15 RULE19
      tdo_oe <= state == ST_SH_IR || state == ST_SH_DR; // RULE14
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      test_active <= 1'b0;
    end else begin
      test_active <= ext_sel || hiz_sel; // RULE10
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [2:0] tms_hi_cnt_ff;

  always_ff @(posedge clk) begin
    if (rst || !trst_n_s) begin
      tms_hi_cnt_ff <= 3'h0;
    end else if (tck_rise) begin
      if (!tms_s) begin
        tms_hi_cnt_ff <= 3'h0;
      end else if (tms_hi_cnt_ff != 3'h5) begin
        tms_hi_cnt_ff <= tms_hi_cnt_ff + 3'h1;
      end
    end
  end

  five_high_reset_a: assert property (@(posedge clk) disable iff (rst) // RULE12
    tms_hi_cnt_ff == 3'h5 |-> state == ST_RESET)
    else $error("five TMS highs did not reach reset");

  trst_reset_a: assert property (@(posedge clk) disable iff (rst) // RULE12
    !trst_n_s |=> state == ST_RESET)
    else $error("TRST low did not force reset");

  ir_reset_value_a: assert property (@(posedge clk) disable iff (rst) // RULE10
    state == ST_RESET |=> ir_ff == IR_RESET)
    else $error("instruction not reinitialised in reset");

  tdo_enable_a: assert property (@(posedge clk) disable iff (rst) // RULE14
    $changed(tdo_oe) |-> $past(tck_fall) && (tdo_oe == ($past(state) == ST_SH_IR || $past(state) == ST_SH_DR)))
    else $error("TDO enable changed outside falling edge rule");

  ir_shift_in_a: assert property (@(posedge clk) disable iff (rst) // RULE16
    tck_rise && state == ST_SH_IR |=> ir_sh_ff[IR_LEN-1] == $past(tdi_s))
    else $error("instruction bit not taken from TDI");

  ir_update_a: assert property (@(posedge clk) disable iff (rst) // RULE2
    tck_fall && state == ST_UPD_IR |=> ir_ff == $past(ir_sh_ff))
    else $error("instruction not updated");

  bypass_path_a: assert property (@(posedge clk) disable iff (rst) // RULE3
    tck_fall && state == ST_SH_DR && dr_sel == SEL_BYP |=> tdo == $past(byp_ff) && tdo_oe)
    else $error("bypass stage not on TDO");

  bypass_decode_a: assert property (@(posedge clk) disable iff (rst) // RULE23
    ir_ff == OP_BYPASS |-> dr_sel == SEL_BYP && !ext_sel && !hiz_sel)
    else $error("all-ones instruction not bypass");

  id_capture_a: assert property (@(posedge clk) disable iff (rst) // RULE24
    cap_dr && dr_sel == SEL_ID |=> id_sh_ff == ID_VALUE)
    else $error("identification value not captured");

  highz_float_a: assert property (@(posedge clk) disable iff (rst) // RULE5
    hiz_sel && $past(hiz_sel) |-> pin_oe == '0)
    else $error("pin driven under HIGHZ");

endmodule : bst_tap_top

// ==== bst_tester.sv ====
`timescale 1ns/10ps
module bst_tester (
  input wire logic clk,
  output logic tck,
  output logic tms,
  output logic tdi,
  output logic trst_n,
  input wire logic tdo,
  input wire logic tdo_oe
);
  // ----------------------------------------------------------------
  // Chain master: TCK stands low between frames
  // ----------------------------------------------------------------
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    trst_n = 1'b1;
  end

  // One TCK period of 8 clk; TDO taken late in the high phase
  task automatic step(input logic m, input logic d, output logic o, output logic oe);
    tms <= m;
    tdi <= d;
    repeat (4) @(posedge clk);
    tck <= 1'b1;
    repeat (4) @(posedge clk);
    o = tdo;
    oe = tdo_oe;
    tck <= 1'b0;
  endtask : step

  // TMS pattern, LSB first; TDI toggles since it is a don't-care here
  task automatic move(input logic [7:0] seq, input int n);
    logic o, oe;
    for (int k = 0; k < n; k++) begin
      step(seq[k], ~tdi, o, oe);
    end
  endtask : move

  // From idle through capture and shift back to idle
  task automatic scan(input logic ir, input logic [63:0] din, input int n, output logic [63:0] dout,
                      output logic all_oe);
    logic o, oe;
    dout = '0;
    all_oe = 1'b1;
    step(1'b1, ~tdi, o, oe);
    if (ir) begin
      step(1'b1, ~tdi, o, oe);
    end
    step(1'b0, ~tdi, o, oe);
    step(1'b0, ~tdi, o, oe);
    for (int k = 0; k < n; k++) begin
      step(k == n - 1, din[k], o, oe);
      dout[k] = o;
      all_oe &= oe;
    end
    step(1'b1, ~tdi, o, oe);
    step(1'b0, ~tdi, o, oe);
  endtask : scan

  task automatic pulse_trst();
    trst_n <= 1'b0;
    repeat (6) @(posedge clk);
    trst_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask : pulse_trst
endmodule : bst_tester

// ==== bst_tap_top_tb.sv ====
`timescale 1ns/10ps
module bst_tap_top_tb import bst_pkg::*;;
  localparam int N = NPINS_DEF;
  localparam logic [31:0] USIG = 32'h5a3c_9e17;
  localparam logic [7:0] INP = 8'hc0;
  localparam logic [7:0] SUP = 8'h40;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [N-1:0] pin_in = '0, keeper_en = '0, core_output_value = '0, core_output_enable = '0;
  logic tck, tms, tdi, trst_n, tdo, tdo_oe, test_active;
  logic [N-1:0] pin_out, pin_oe, pin_hold, core_input_drive;
  int fails = 0;
  int checked = 0;
  int cyc = 0;
  int ir_m;
  logic [23:0] upd_m;

  bst_tap_top #(.USER_SIG(USIG), .INPUT_ONLY(INP), .SUPPLY_SEL(SUP)) u_bst_tap_top (
    .clk(clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo),
    .tdo_oe(tdo_oe), .test_active(test_active), .pin_in(pin_in), .keeper_en(keeper_en),
    .core_output_value(core_output_value), .core_output_enable(core_output_enable),
    .pin_out(pin_out), .pin_oe(pin_oe), .pin_hold(pin_hold), .core_input_drive(core_input_drive));

  bst_tester u_bst_tester (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n),
    .tdo(tdo), .tdo_oe(tdo_oe));

  initial begin
    forever #5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Reference model and checks
  // ----------------------------------------------------------------
  task automatic test_done();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : test_done

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic rand_pins();
    pin_in <= N'($urandom);
    keeper_en <= N'($urandom);
    core_output_value <= N'($urandom);
    core_output_enable <= N'($urandom);
    @(posedge clk);
  endtask : rand_pins

  // Chain bit 3i is cell i input stage, then enable (1 = float), then output
  function automatic logic [63:0] cap_bsr();
    logic [63:0] c;
    c = '0;
    for (int i = 0; i < N; i++) begin
      c[3*i] = pin_in[i];
      c[3*i+1] = INP[i] ? 1'b0 : ~core_output_enable[i];
      c[3*i+2] = INP[i] ? 1'b0 : core_output_value[i];
    end
    return c;
  endfunction : cap_bsr

  task automatic load_ir(input int op);
    logic [63:0] o;
    logic oe;
    u_bst_tester.scan(1'b1, 64'(op), IR_LEN_DEF, o, oe);
    chk("ir_out", 64'(ir_m), o[IR_LEN_DEF-1:0]);
    chk("ir_tdo_oe", 1, oe);
    ir_m = op;
    repeat (6) @(posedge clk);
    chk("idle_tdo_oe", 0, tdo_oe);
  endtask : load_ir

  // Captured value leaves first, then TDI data after the path length
  task automatic dr_run(input int n);
    logic [63:0] din, o, cap, msk;
    logic oe;
    int len;
    din = {$urandom, $urandom};
    len = 1;
    cap = '0;
    if (ir_m == OP_IDCODE_DEF) begin
      len = ID_LEN;
      cap = 64'(ID_VALUE_DEF);
    end else if (ir_m == OP_USERCODE_DEF) begin
      len = 32;
      cap = 64'(USIG);
    end else if (ir_m == OP_SAMPLE_DEF || ir_m == OP_EXTEST_DEF) begin
      len = 3 * N;
      cap = cap_bsr();
    end
    msk = (64'h1 << n) - 64'h1;
    u_bst_tester.scan(1'b0, din, n, o, oe);
    chk("dr_out", ((din << len) | cap) & msk, o & msk);
    chk("dr_tdo_oe", 1, oe);
    if (len == 3 * N) upd_m = 24'(din >> (n - len));
  endtask : dr_run

  task automatic chk_pins();
    logic [7:0] po, pe, ci, ph;
    logic tm, hz, ts;
    repeat (6) @(posedge clk);
    tm = (ir_m == OP_EXTEST_DEF || ir_m == OP_CLAMP_DEF);
    hz = (ir_m == OP_HIGHZ_DEF);
    // Supply-select cells stay functional outside HIGHZ; input-only cells never drive
    for (int i = 0; i < N; i++) begin
      ts = tm && !SUP[i];
      po[i] = ts ? upd_m[3*i+2] : core_output_value[i];
      pe[i] = !hz && !INP[i] && (ts ? ~upd_m[3*i+1] : core_output_enable[i]);
      ci[i] = ts ? upd_m[3*i] : pin_in[i];
      ph[i] = (ts || hz) && keeper_en[i] && !pe[i];
    end
    chk("test_active", tm || hz, test_active);
    chk("pin_oe", pe, pin_oe);
    chk("pin_hold", ph, pin_hold);
    chk("pin_out", po, pin_out);
    chk("core_input_drive", ci, core_input_drive);
  endtask : chk_pins

  // ----------------------------------------------------------------
  // Hang guard, about three times the expected run
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 15000) begin
      fails++;
      test_done();
    end
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'hbe280023));
    ir_m = OP_IDCODE_DEF;
    upd_m = '0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rand_pins();
    repeat (4) @(posedge clk);
    u_bst_tester.move(8'h00, 1);
    dr_run(40);
    chk_pins();
    $display("test idcode done");
    load_ir(OP_USERCODE_DEF);
    dr_run(36);
    $display("test usercode done");
    for (int op = 6; op < 16; op++) begin
      load_ir(op);
      dr_run(9);
    end
    $display("test bypass done");
    rand_pins();
    load_ir(OP_SAMPLE_DEF);
    chk_pins();
    dr_run(3 * N + 8);
    chk_pins();
    $display("test sample done");
    load_ir(OP_EXTEST_DEF);
    chk_pins();
    rand_pins();
    dr_run(3 * N + 5);
    chk_pins();
    $display("test extest done");
    load_ir(OP_CLAMP_DEF);
    dr_run(5);
    chk_pins();
    load_ir(OP_HIGHZ_DEF);
    dr_run(5);
    chk_pins();
    $display("test clamp highz done");
    u_bst_tester.move(8'h1f, 5);
    ir_m = OP_IDCODE_DEF;
    u_bst_tester.move(8'h00, 1);
    chk_pins();
    load_ir(OP_EXTEST_DEF);
    u_bst_tester.pulse_trst();
    ir_m = OP_IDCODE_DEF;
    u_bst_tester.move(8'h00, 1);
    dr_run(33);
    chk_pins();
    $display("test tap reset done");
    load_ir(OP_CLAMP_DEF);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    ir_m = OP_IDCODE_DEF;
    u_bst_tester.move(8'h00, 1);
    chk_pins();
    dr_run(32);
    $display("test mid-run reset done");
    test_done();
  end
endmodule : bst_tap_top_tb
